//--- design/synth_pkg.sv
// Purpose: constants shared by the system clock synthesizer control block.
// Assumes: 250 MHz control clock; 16-bit register port.
// Notes:   offsets, field positions, reset values and cycle counts live here.
package synth_pkg;
	localparam int          CLK_PERIOD_NS  = 4;
	localparam int          RELOCK_NS      = 1000;
	localparam int          RELOCK_CYCLES  = (RELOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          ADDR_W         = 8;
	localparam int          DATA_W         = 16;
	localparam int          MOD_W          = 6;
	localparam int          PRE_W          = 3;
	localparam int          SYS_MULT_W     = 12;
	localparam int          VCO_MULT_W     = 13;
	localparam int          NUM_EV         = 3;

	localparam logic [7:0]  ADDR_SYNTH     = 8'h00;
	localparam logic [7:0]  ADDR_STATUS    = 8'h04;
	localparam logic [7:0]  ADDR_CLEAR     = 8'h08;
	localparam logic [7:0]  ADDR_ENABLE    = 8'h0C;

	localparam int          SPEED_BIT      = 15;
	localparam int          PRESCALE_BIT   = 14;
	localparam int          MOD_MSB        = 13;
	localparam int          MOD_LSB        = 8;
	localparam int          LOCK_BIT       = 3;
	localparam logic [15:0] SYNTH_RESET    = 16'h3F00;

	localparam int          EV_LOCKED      = 0;
	localparam int          EV_UNLOCKED    = 1;
	localparam int          EV_PRIV        = 2;

	localparam logic [2:0]  PRE_TC_FAST    = 3'h3;
	localparam logic [2:0]  PRE_TC_SLOW    = 3'h0;

	typedef enum logic [1:0] {
		ST_STRAP,
		ST_BYPASS,
		ST_ACQUIRE,
		ST_LOCKED
	} clk_state_t;
endpackage : synth_pkg

//--- design/feedback_divider.sv
// Purpose: digital feedback divider of the synthesizer loop.
// Assumes: clk stands in for the VCO edge in this digital model.
// Notes:   tick period is (Y+1) times 1 or 4 input edges.
`timescale 1ns/1ps
module feedback_divider
	import synth_pkg::*;
(
	input  wire logic                    clk,        // control clock
	input  wire logic                    reset,      // async, active high
	input  wire logic                    run,        // divider enabled
	input  wire logic                    vcoSpeed,   // speed bit
	input  wire logic [synth_pkg::MOD_W-1:0] modulus,  // feedback modulus Y
	output      logic                    fbTick      // one pulse per divided period
);
	logic [PRE_W-1:0] preCnt_q;
	logic [MOD_W-1:0] modCnt_q;
	logic             preWrap;

	assign preWrap = (preCnt_q == (vcoSpeed ? PRE_TC_FAST : PRE_TC_SLOW));

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			preCnt_q <= '0;
		end else if (!run || preWrap) begin
			preCnt_q <= '0;
		end else begin
			preCnt_q <= preCnt_q + 3'h1;
		end
	end

	// down counter reloads Y at zero, so it divides by Y+1
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			modCnt_q <= '0;
			fbTick   <= 1'b0;
		end else begin
			fbTick <= run && preWrap && (modCnt_q == '0);
			if (!run) begin
				modCnt_q <= modulus;
			end else if (preWrap) begin
				modCnt_q <= (modCnt_q == '0) ? modulus : modCnt_q - 6'h01;
			end
		end
	end
endmodule : feedback_divider

//--- design/relock_timer.sv
// Purpose: relock delay and lock qualification.
// Assumes: lockIn is the analog loop's raw lock indication, synchronous.
// Notes:   loss of lockIn re-arms the full delay.
`timescale 1ns/1ps
module relock_timer
	import synth_pkg::*;
#(
	parameter int DELAY = synth_pkg::RELOCK_CYCLES
)(
	input  wire logic clk,      // control clock
	input  wire logic reset,    // async, active high
	input  wire logic restart,  // pulse: comparator input changed
	input  wire logic lockIn,   // raw analog lock
	output      logic locked    // qualified lock
);
	logic [15:0] cnt_q;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_q  <= 16'(DELAY);
			locked <= 1'b0;
		end else if (restart || !lockIn) begin
			cnt_q  <= 16'(DELAY);
			locked <= 1'b0;
		end else if (cnt_q != 16'h0000) begin
			cnt_q  <= cnt_q - 16'h0001;
			locked <= 1'b0;
		end else begin
			locked <= 1'b1;
		end
	end
endmodule : relock_timer

//--- design/pll_system_clock_synth.sv
// Purpose: control side of the system clock generator.
// Assumes: register strobes and all inputs except the async reset synchronous to clk.
// Notes:   the analog loop is outside; this block steers and watches it.
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module pll_system_clock_synth
	import synth_pkg::*;
(
	input  wire logic                          clk,            // 250 MHz control clock
	input  wire logic                          reset,          // async, active high
	input  wire logic                          clockSourceSelectPin, // strap
	input  wire logic                          lockIn,         // raw lock from loop
	input  wire logic                          supervisor,     // processor privilege
	input  wire logic [synth_pkg::ADDR_W-1:0]  addr,           // register address
	input  wire logic [synth_pkg::DATA_W-1:0]  wrData,         // write data
	input  wire logic                          wrEn,           // write strobe
	input  wire logic                          rdEn,           // read strobe
	output      logic [synth_pkg::DATA_W-1:0]  rdData,         // read data, next cycle
	output      logic                          synthEnable,    // synthesizer on
	output      logic                          vcoSpeed,       // applied speed bit
	output      logic                          outPrescale,    // applied prescale bit
	output      logic [synth_pkg::MOD_W-1:0]   fbModulus,      // applied modulus
	output      logic                          fbTick,         // divided feedback pulse
	output      logic [synth_pkg::SYS_MULT_W-1:0] sysMult,     // system/ref ratio
	output      logic [synth_pkg::VCO_MULT_W-1:0] vcoMult,     // vco/ref ratio
	output      logic                          synth_lock_flag, // qualified lock
	output      logic                          sysReset,       // chip reset out
	output      logic                          irq             // level interrupt
);
	////////////////////////////////////////////////////////////////////////////
	// state

	clk_state_t       state_q;
	logic             speed_q;
	logic             prescale_q;
	logic [MOD_W-1:0] modulus_q;
	logic             restart_q;
	logic             lockedRaw;
	logic             lockedPrev_q;
	logic             fbTickRaw;
	logic [NUM_EV-1:0] status_q;
	logic [NUM_EV-1:0] enable_q;
	logic [NUM_EV-1:0] events;
	logic [NUM_EV-1:0] clearMask;
	logic             wrSynth;
	logic             wrClear;
	logic             wrEnable;
	logic             relockNeeded;
	logic             privFault;
	logic             synthOn;
	logic [SYS_MULT_W-1:0] sysMult_d;
	logic [VCO_MULT_W-1:0] vcoMult_d;

	assign synthOn  = (state_q == ST_ACQUIRE) || (state_q == ST_LOCKED);
	assign wrSynth  = wrEn && (addr == ADDR_SYNTH);
	assign wrClear  = wrEn && (addr == ADDR_CLEAR);
	assign wrEnable = wrEn && (addr == ADDR_ENABLE);

	// only speed or modulus moves the comparator input; prescale sits after it
	assign relockNeeded = wrSynth && synthOn &&
		((wrData[SPEED_BIT] != speed_q) ||
		 (wrData[MOD_MSB:MOD_LSB] != modulus_q));

	assign privFault = rdEn && (addr == ADDR_SYNTH) && !supervisor;

	////////////////////////////////////////////////////////////////////////////
	// clock source selection and reset sequencing

	// strap is caught by the first edge after release, never by the reset itself
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= ST_STRAP;
		end else begin
			case (state_q)
				ST_STRAP: begin
					if (clockSourceSelectPin) begin
						state_q <= ST_ACQUIRE;
					end else begin
						state_q <= ST_BYPASS;
					end
				end
				ST_BYPASS: begin
					state_q <= ST_BYPASS;
				end
				ST_ACQUIRE: begin
					if (lockedRaw && !restart_q) begin
						state_q <= ST_LOCKED;
					end
				end
				ST_LOCKED: begin
					if (!lockedRaw || restart_q) begin
						state_q <= ST_ACQUIRE;
					end
				end
				default: begin
					state_q <= ST_STRAP;
				end
			endcase
		end
	end

	// chip stays in reset until a clock it can trust is present
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sysReset <= 1'b1;
		end else if (state_q == ST_BYPASS) begin
			sysReset <= 1'b0;
		end else if (state_q == ST_LOCKED && sysReset) begin
			sysReset <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			synthEnable <= 1'b0;
		end else begin
			synthEnable <= (state_q == ST_ACQUIRE) || (state_q == ST_LOCKED) ||
				(state_q == ST_STRAP && clockSourceSelectPin);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// synthesizer control register

	// stored in every mode so software reads back what it wrote; fully static,
	// so nothing here is disturbed when the system clock rate moves
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			speed_q    <= SYNTH_RESET[SPEED_BIT];
			prescale_q <= SYNTH_RESET[PRESCALE_BIT];
			modulus_q  <= SYNTH_RESET[MOD_MSB:MOD_LSB];
		end else if (wrSynth) begin
			speed_q    <= wrData[SPEED_BIT];
			prescale_q <= wrData[PRESCALE_BIT];
			modulus_q  <= wrData[MOD_MSB:MOD_LSB];
		end
	end

	// values reach the loop only while the synthesizer runs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			vcoSpeed    <= SYNTH_RESET[SPEED_BIT];
			outPrescale <= SYNTH_RESET[PRESCALE_BIT];
			fbModulus   <= SYNTH_RESET[MOD_MSB:MOD_LSB];
		end else if (synthOn) begin
			vcoSpeed    <= speed_q;
			outPrescale <= prescale_q;
			fbModulus   <= modulus_q;
		end else begin
			vcoSpeed    <= vcoSpeed;
			outPrescale <= outPrescale;
			fbModulus   <= fbModulus;
		end
	end

	// restart also covers the first acquisition after the strap
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			restart_q <= 1'b0;
		end else begin
			restart_q <= relockNeeded ||
				(state_q == ST_STRAP && clockSourceSelectPin);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// frequency ratios

	always_comb begin
		sysMult_d = SYS_MULT_W'(({6'h00, fbModulus} + 12'h001) << 2);
		sysMult_d = sysMult_d << ({vcoSpeed, 1'b0} + {1'b0, outPrescale});
		if (outPrescale) begin
			vcoMult_d = {1'b0, sysMult_d} << 1;
		end else begin
			vcoMult_d = {1'b0, sysMult_d} << 2;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sysMult <= '0;
			vcoMult <= '0;
		end else if (synthOn) begin
			sysMult <= sysMult_d;
			vcoMult <= vcoMult_d;
		end else begin
			sysMult <= '0;
			vcoMult <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// loop pieces

	feedback_divider u_divider (
		.clk      (clk),
		.reset    (reset),
		.run      (synthOn),
		.vcoSpeed (vcoSpeed),
		.modulus  (fbModulus),
		.fbTick   (fbTickRaw)
	);

	relock_timer #(
		.DELAY (RELOCK_CYCLES)
	) u_relock (
		.clk     (clk),
		.reset   (reset),
		.restart (restart_q),
		.lockIn  (lockIn && synthOn),
		.locked  (lockedRaw)
	);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fbTick <= 1'b0;
		end else begin
			fbTick <= fbTickRaw;
		end
	end

	// flag is one only in the locked state, zero during acquisition or loss
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			synth_lock_flag <= 1'b0;
		end else begin
			synth_lock_flag <= (state_q == ST_LOCKED) && lockedRaw && !restart_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// events and interrupt

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lockedPrev_q <= 1'b0;
		end else begin
			lockedPrev_q <= synth_lock_flag;
		end
	end

	always_comb begin
		events              = '0;
		events[EV_LOCKED]   = synth_lock_flag && !lockedPrev_q;
		events[EV_UNLOCKED] = !synth_lock_flag && lockedPrev_q;
		events[EV_PRIV]     = privFault;
		clearMask           = wrClear ? wrData[NUM_EV-1:0] : '0;
	end

	// a new event beats a clear in the same cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			status_q <= '0;
		end else begin
			status_q <= (status_q & ~clearMask) | events;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			enable_q <= '0;
		end else if (wrEnable) begin
			enable_q <= wrData[NUM_EV-1:0];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((status_q & ~clearMask) | events) & enable_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read port

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdData <= '0;
		end else if (rdEn) begin
			case (addr)
				ADDR_SYNTH: begin
					if (supervisor) begin
						rdData                   <= '0;
						rdData[SPEED_BIT]        <= speed_q;
						rdData[PRESCALE_BIT]     <= prescale_q;
						rdData[MOD_MSB:MOD_LSB]  <= modulus_q;
						rdData[LOCK_BIT]         <= synth_lock_flag;
					end else begin
						rdData <= '0;
					end
				end
				ADDR_STATUS: begin
					rdData <= {{(DATA_W-NUM_EV){1'b0}}, status_q};
				end
				ADDR_ENABLE: begin
					rdData <= {{(DATA_W-NUM_EV){1'b0}}, enable_q};
				end
				default: begin
					rdData <= '0;
				end
			endcase
		end else begin
			rdData <= '0;
		end
	end
endmodule : pll_system_clock_synth

//--- testbench/lock_source_model.sv
// Purpose: reference source and analog loop as seen by the control block.
// Assumes: the loop settles a fixed number of cycles after any change.
// Notes:   drop forces one loss of lock on command of the bench.
`timescale 1ns/1ps
module lock_source_model #(
	parameter int SETTLE = 20
)(
	input  wire logic       clk,     // clock
	input  wire logic       reset,   // async reset
	input  wire logic       enable,  // loop on
	input  wire logic       speed,   // speed bit
	input  wire logic [5:0] modulus, // modulus
	input  wire logic       drop,    // force loss
	output      logic       lockIn   // raw lock
);
	logic [6:0] cfg_q;
	int         count_q;
	////////////////////////////////////////
	// prescale is not watched: it sits outside the loop
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg_q <= 7'h00;
			count_q <= SETTLE;
			lockIn <= 1'b0;
		end else begin
			cfg_q <= {speed, modulus};
			if (!enable || drop || {speed, modulus} != cfg_q) begin
				count_q <= SETTLE;
				lockIn <= 1'b0;
			end else if (count_q != 0) begin
				count_q <= count_q - 1;
			end else begin
				lockIn <= 1'b1;
			end
		end
	end
endmodule : lock_source_model

//--- testbench/synth_checker.sv
// Purpose: port checks of the clock synthesizer control block.
// Assumes: default relock delay at the top module.
// Notes:   ratios are judged only once the controls have settled.
`timescale 1ns/1ps
module synth_checker
	import synth_pkg::*;
(
	input wire logic        clk,             // clock
	input wire logic        reset,           // reset
	input wire logic        lockIn,          // raw lock
	input wire logic        supervisor,      // privilege
	input wire logic [7:0]  addr,            // address
	input wire logic [15:0] wrData,          // write data
	input wire logic        wrEn,            // write
	input wire logic        rdEn,            // read
	input wire logic [15:0] rdData,          // read data
	input wire logic        synthEnable,     // synth on
	input wire logic        vcoSpeed,        // speed
	input wire logic        outPrescale,     // prescale
	input wire logic [5:0]  fbModulus,       // modulus
	input wire logic [11:0] sysMult,         // sys ratio
	input wire logic [12:0] vcoMult,         // vco ratio
	input wire logic        synth_lock_flag, // lock
	input wire logic        sysReset         // chip reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	wire logic [7:0] cfg = {vcoSpeed, outPrescale, fbModulus};
	wire logic ctlWr = wrEn && addr == ADDR_SYNTH && synthEnable;
	////////////////////////////////////////
	bypass_hold_a: assert property (!synthEnable |-> fbModulus == 6'h3F && !vcoSpeed)
		else $error("control applied in bypass");
	relock_drop_a: assert property (ctlWr && wrData[13:8] != fbModulus |-> ##[1:3] !synth_lock_flag)
		else $error("no relock after modulus change");
	loss_drop_a: assert property (synthEnable && !lockIn |-> ##[0:2] !synth_lock_flag)
		else $error("lock flag kept without loop lock");
	lock_wait_a: assert property ($rose(lockIn) |-> !synth_lock_flag [*8])
		else $error("lock flag without relock delay");
	reset_lock_a: assert property (synthEnable && $fell(sysReset) |-> synth_lock_flag || $past(synth_lock_flag))
		else $error("reset released before lock");
	sys_ratio_a: assert property ((synthEnable && $stable(cfg)) [*3] |->
		sysMult == 12'((12'(fbModulus) + 12'h001) << (2 + 2 * vcoSpeed + outPrescale)))
		else $error("system ratio wrong");
	vco_ratio_a: assert property ((synthEnable && $stable(cfg)) [*3] |->
		vcoMult == (13'(sysMult) << (outPrescale ? 1 : 2)))
		else $error("vco ratio wrong");
	priv_read_a: assert property (rdEn && addr == ADDR_SYNTH && !supervisor |=> rdData == 16'h0000)
		else $error("control read without privilege");
	lock_read_a: assert property (rdEn && addr == ADDR_SYNTH && supervisor |=>
		rdData[LOCK_BIT] == $past(synth_lock_flag))
		else $error("lock bit reads wrong");
	strap_once_a: assert property (!$past(reset) && !$past(reset, 2) && !$past(reset, 3) |->
		$stable(synthEnable))
		else $error("clock source changed after reset");
endmodule : synth_checker
bind pll_system_clock_synth synth_checker chk (
	.clk(clk), .reset(reset), .lockIn(lockIn), .supervisor(supervisor), .addr(addr),
	.wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .synthEnable(synthEnable),
	.vcoSpeed(vcoSpeed), .outPrescale(outPrescale), .fbModulus(fbModulus),
	.sysMult(sysMult), .vcoMult(vcoMult), .synth_lock_flag(synth_lock_flag),
	.sysReset(sysReset)
);

//--- testbench/tb.sv
// Purpose: self-checking bench of the clock synthesizer control block.
// Assumes: default relock delay; loop model settles in 20 cycles.
// Notes:   reset leads; rows cover ratios; events, privilege, bypass follow.
`timescale 1ns/1ps
module tb;
	import synth_pkg::*;
	typedef struct packed {
		logic [15:0] cfg;
		logic [11:0] sys;
		logic [12:0] vco;
	} row_t;
	row_t rows [6] = '{'{16'h0000, 12'h004, 13'h010}, '{16'h4000, 12'h008, 13'h010},
		'{16'h8500, 12'h060, 13'h180}, '{16'hFF00, 12'h800, 13'h1000},
		'{16'h1F00, 12'h080, 13'h200}, '{16'h3F00, 12'h100, 13'h400}};
	logic        clk = 0, reset = 1, strap = 1, supervisor = 1;
	logic        wrEn = 0, rdEn = 0, drop = 0, lockIn, fbTick, irq;
	logic        synthEnable, vcoSpeed, outPrescale, lockFlag, sysReset;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wrData = 16'h0000, rdData, d;
	logic [5:0]  fbModulus;
	logic [11:0] sysMult;
	logic [12:0] vcoMult;
	int          n_fail = 0, checked = 0, g;
	always #2 clk = ~clk;
	pll_system_clock_synth dut (.clk(clk), .reset(reset), .clockSourceSelectPin(strap),
		.lockIn(lockIn), .supervisor(supervisor), .addr(addr), .wrData(wrData),
		.wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .synthEnable(synthEnable),
		.vcoSpeed(vcoSpeed), .outPrescale(outPrescale), .fbModulus(fbModulus),
		.fbTick(fbTick), .sysMult(sysMult), .vcoMult(vcoMult),
		.synth_lock_flag(lockFlag), .sysReset(sysReset), .irq(irq));
	lock_source_model src (.clk(clk), .reset(reset), .enable(synthEnable),
		.speed(vcoSpeed), .modulus(fbModulus), .drop(drop), .lockIn(lockIn));
	////////////////////////////////////////
	task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wrData <= v;
		wrEn <= 1'b1;
		@(posedge clk);
		wrEn <= 1'b0;
	endtask : wr
	task automatic rd(logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge clk);
		rdEn <= 1'b0;
		#1 d = rdData;
	endtask : rd
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	// bounded: a lost lock must not hang the run
	task automatic waitLock();
		for (g = 0; g < 600 && lockFlag !== 1'b1; g++) step(1);
		chk("lock", 16'(lockFlag), 16'h0001);
	endtask : waitLock
	task automatic test_done();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		test_done();
	end
	////////////////////////////////////////
	initial begin
		step(7);
		chk("held reset", 16'(sysReset), 16'h0001);
		chk("reset modulus", 16'(fbModulus), 16'h003F);
		@(posedge clk) reset <= 1'b0;
		step(3);
		chk("early reset", 16'(sysReset), 16'h0001);
		waitLock();
		step(8);
		chk("synth mode", 16'(synthEnable), 16'h0001);
		chk("reset out", 16'(sysReset), 16'h0000);
		rd(ADDR_SYNTH);
		chk("control", d & 16'hFF08, 16'h3F08);
		wr(ADDR_ENABLE, 16'h0004);
		foreach (rows[i]) begin
			wr(ADDR_SYNTH, rows[i].cfg);
			step(4);
			waitLock();
			chk("modulus", 16'(fbModulus), 16'(rows[i].cfg[13:8]));
			chk("speed", 16'({vcoSpeed, outPrescale}), 16'(rows[i].cfg[15:14]));
			chk("sys ratio", 16'(sysMult), 16'(rows[i].sys));
			chk("vco ratio", 16'(vcoMult), 16'(rows[i].vco));
			for (g = 0; g < 300 && fbTick !== 1'b1; g++) step(1);
			g = 0;
			do begin
				step(1);
				g++;
			end while (fbTick !== 1'b1 && g < 300);
			chk("tick gap", 16'(g), 16'((rows[i].cfg[13:8] + 1) * (rows[i].cfg[15] ? 4 : 1)));
			rd(ADDR_SYNTH);
			chk("readback", d & 16'hFF08, rows[i].cfg | 16'h0008);
		end
		rd(ADDR_ENABLE);
		chk("enable kept", d, 16'h0004);
		wr(ADDR_CLEAR, 16'h0007);
		@(posedge clk) drop <= 1'b1;
		@(posedge clk) drop <= 1'b0;
		step(4);
		chk("lost lock", 16'(lockFlag), 16'h0000);
		waitLock();
		rd(ADDR_STATUS);
		chk("lock events", d & 16'h0007, 16'h0003);
		@(posedge clk) supervisor <= 1'b0;
		rd(ADDR_SYNTH);
		chk("guarded read", d, 16'h0000);
		supervisor <= 1'b1;
		step(2);
		chk("irq set", 16'(irq), 16'h0001);
		wr(ADDR_CLEAR, 16'h0004);
		step(2);
		chk("irq clear", 16'(irq), 16'h0000);
		wr(ADDR_ENABLE, 16'h0000);
		@(posedge clk) supervisor <= 1'b0;
		rd(ADDR_SYNTH);
		supervisor <= 1'b1;
		step(2);
		chk("irq masked", 16'(irq), 16'h0000);
		rd(ADDR_STATUS);
		chk("sticky", d & 16'h0004, 16'h0004);
		rd(8'h10);
		chk("unmapped", d, 16'h0000);
		@(posedge clk) begin
			reset <= 1'b1;
			strap <= 1'b0;
		end
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		strap <= 1'b1;
		wr(ADDR_SYNTH, 16'h8500);
		step(10);
		chk("bypass mode", 16'(synthEnable), 16'h0000);
		chk("bypass reset", 16'(sysReset), 16'h0000);
		chk("bypass modulus", 16'(fbModulus), 16'h003F);
		chk("bypass ratio", 16'(sysMult), 16'h0000);
		test_done();
	end
endmodule : tb
